// ===== logic/evum_params.svh
// Offsets, reset values and code points of the event user mux
`ifndef EVUM_PARAMS_SVH
`define EVUM_PARAMS_SVH

// ==========================================================
// Register map
`define EVUM_USER_BASE      8'h20
`define EVUM_NUM_USERS      25
`define EVUM_SEL_RST        8'h00
`define EVUM_SEL_OFF        8'h00

// ==========================================================
// Generator codes
`define EVUM_GEN_B0_CAPTURE 8'ha0
`define EVUM_GEN_B0_WRAP    8'ha1
`define EVUM_GEN_B1_CAPTURE 8'ha2
`define EVUM_GEN_B1_WRAP    8'ha3
`define EVUM_GEN_B2_CAPTURE 8'ha4
`define EVUM_GEN_B2_WRAP    8'ha5
`define EVUM_GEN_PIN_BASE   8'h40
`define EVUM_NUM_PINS       8

// ==========================================================
// User indices of the third type-B timer
`define EVUM_USER_B2_CAPTURE 21
`define EVUM_USER_B2_COUNT   22

`endif

// ===== logic/evum_pkg.sv
// Types shared by the event user mux
package evum_pkg;

  // ========================================================
  // Type-B timer operating modes
  typedef enum logic [2:0] {
    EVUM_TB_PERIODIC    = 3'b000,
    EVUM_TB_TIMEOUT     = 3'b001,
    EVUM_TB_INPUT_CAPTURE_FLAG_EVENT  = 3'b010,
    EVUM_TB_FREQ        = 3'b011,
    EVUM_TB_PULSE_WIDTH = 3'b100,
    EVUM_TB_FREQ_PW     = 3'b101,
    EVUM_TB_SINGLE_SHOT = 3'b110,
    EVUM_TB_PWM8        = 3'b111
  } evum_tb_mode_t;

  // ========================================================
  // Event inputs from one type-B timer
  typedef struct packed {
    logic          capture;
    logic          wrap;
    evum_tb_mode_t mode;
  } evum_tb_in_t;

  // ========================================================
  // One bit per event user, user 24 first
  typedef struct packed {
    logic tmr_d_input_b;
    logic tmr_d_input_a;
    logic timer_b_inst2_count;
    logic timer_b_inst2_capture;
    logic timer_b_inst1_count;
    logic timer_b_inst1_capture;
    logic timer_b_inst0_count;
    logic timer_b_inst0_capture;
    logic timer_a_inst0_count_input_b;
    logic timer_a_inst0_count_input_a;
    logic serial_port1_irda;
    logic serial_port0_irda;
    logic pin_out_f;
    logic pin_out_d;
    logic pin_out_c;
    logic pin_out_a;
    logic adc_start;
    logic table3_event_in_b;
    logic table3_event_in_a;
    logic table2_event_in_b;
    logic table2_event_in_a;
    logic table1_event_in_b;
    logic table1_event_in_a;
    logic table0_event_in_b;
    logic table0_event_in_a;
  } evum_users_t;

endpackage : evum_pkg

// ===== logic/evum_user_sel.sv
// One user channel-selection register and its channel picker
`timescale 1ns/1ps

`include "evum_params.svh"

module evum_user_sel
  import evum_pkg::*;
#(
  parameter int NUM_CHAN = 6,
  parameter bit PRESENT  = 1'b1
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire logic                wr_en,
  input  wire logic [7:0]          wdata,
  input  wire logic [NUM_CHAN-1:0] chan_evt,
  output logic      [7:0]          sel,
  output logic                     user_evt
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic next_user;

  // ========================================================
  // Selection register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel <= `EVUM_SEL_RST;
    end else if (clk_en && wr_en && PRESENT) begin // RQ2
      sel <= wdata; // RQ5
    end
  end

  // ========================================================
  // Channel picker: one channel at most
  always_comb begin
    next_user = 1'b0; // RQ7 RQ14
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (sel == 8'(c + 1)) begin
        next_user = chan_evt[c]; // RQ6 RQ7
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      user_evt <= 1'b0;
    end else if (clk_en) begin
      user_evt <= next_user;
    end
  end

  // ========================================================
  // Checks
  a_sel_off_quiet: assert property ( // RQ7
    clk_en && sel == `EVUM_SEL_OFF |=> !user_evt)
    else $error("user active while disconnected");

  a_sel_bad_quiet: assert property ( // RQ14
    clk_en && sel > 8'(NUM_CHAN) |=> !user_evt)
    else $error("user active on missing channel");

  a_sel_absent: assert property ( // RQ2
    !PRESENT |-> sel == `EVUM_SEL_OFF)
    else $error("absent user holds a selection");

endmodule : evum_user_sel

// ===== logic/evum_mux.sv
// Event user channel mux: generator decode and user selectors
//
// Function
// RQ1: Codes a2-a5 pick timer B1/B2 capture, wrap
// RQ2: Third type-B timer exists only when fitted
// RQ3: Pin event reads zero when driver disabled
// RQ4: Capture event moment follows timer operating mode
// RQ5: Eight-bit selector per user at 0x20+n
// RQ6: User takes one channel; channels shareable
// RQ7: Zero disconnects; n picks channel n-1
// RQ8: Users 0-7 are logic table A/B inputs
// RQ9: Users 0x0d, 0x0e are serial IrDA inputs
// RQ10: User 0x0f is timer A count input A
// RQ11: User 0x10 is timer A count input B
// RQ12: Users 0x11-0x16 are type-B capture/count inputs
// RQ13: Capture input path sync/async set by mode
// RQ14: Missing channel treated as disconnected
//
// Strobed register access was decided locally.
`timescale 1ns/1ps

`include "evum_params.svh"

module evum_mux
  import evum_pkg::*;
#(
  parameter int NUM_CHAN     = 6,
  parameter bit HAS_TIMER_B2 = 1'b1
) (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     clk_en,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [7:0]               reg_rdata,
  input  wire logic [NUM_CHAN-1:0][7:0] gen_code,
  input  wire logic [NUM_CHAN-1:0]      chan_other,
  input  wire logic [7:0]               pin_event,
  input  wire logic [7:0]               pin_drv_en,
  input  wire evum_tb_in_t [2:0]        timer_b,
  output logic      [NUM_CHAN-1:0]      chan_evt,
  output logic      [2:0]               capture_async,
  output evum_users_t                   users
);

  localparam int         NUSR     = `EVUM_NUM_USERS;
  localparam logic [7:0] PIN_BASE = `EVUM_GEN_PIN_BASE;
  localparam logic [7:0] USR_BASE = `EVUM_USER_BASE;
  localparam logic [7:0] USR_CNT  = 8'(`EVUM_NUM_USERS);
  localparam logic [7:0] USR_LAST = USR_BASE + USR_CNT - 8'h01;

  // ========================================================
  // Reset release
  logic [1:0] rst_pipe;
  logic       rst_n;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ========================================================
  // Type-B timer event shaping
  logic [2:0] tb_present;
  logic [2:0] tb_capture_evt;
  logic [2:0] tb_wrap_evt;
  logic [2:0] next_async;

  for (genvar t = 0; t < 3; t++) begin : g_timer
    assign tb_present[t] = (t < 2) || HAS_TIMER_B2; // RQ2

    always_comb begin
      tb_capture_evt[t] = 1'b0;
      tb_wrap_evt[t]    = 1'b0;
      next_async[t]     = 1'b0;
      if (tb_present[t]) begin
        tb_wrap_evt[t] = timer_b[t].wrap;
        // Periodic mode flags capture on the wrap
        if (timer_b[t].mode == EVUM_TB_PERIODIC) begin
          tb_capture_evt[t] = timer_b[t].wrap; // RQ4
        end else begin
          tb_capture_evt[t] = timer_b[t].capture; // RQ4
        end
        next_async[t] =
          (timer_b[t].mode == EVUM_TB_SINGLE_SHOT); // RQ13
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_async <= 3'b000;
    end else if (clk_en) begin
      capture_async <= next_async; // RQ13
    end
  end

  // ========================================================
  // Channel generator decode
  logic [NUM_CHAN-1:0] next_chan;

  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    logic [7:0] code;
    logic       src;

    assign code = gen_code[c];

    always_comb begin
      src = chan_other[c];
      case (code)
        `EVUM_GEN_B0_CAPTURE: src = tb_capture_evt[0];
        `EVUM_GEN_B0_WRAP:    src = tb_wrap_evt[0];
        `EVUM_GEN_B1_CAPTURE: src = tb_capture_evt[1]; // RQ1
        `EVUM_GEN_B1_WRAP:    src = tb_wrap_evt[1]; // RQ1
        `EVUM_GEN_B2_CAPTURE: src = tb_capture_evt[2]; // RQ1 RQ2
        `EVUM_GEN_B2_WRAP:    src = tb_wrap_evt[2]; // RQ1 RQ2
        default: begin
          if (code[7:3] == PIN_BASE[7:3]) begin
            src = pin_event[code[2:0]] &
                  pin_drv_en[code[2:0]]; // RQ3
          end
        end
      endcase
    end

    assign next_chan[c] = src;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_evt <= '0;
    end else if (clk_en) begin
      chan_evt <= next_chan;
    end
  end

  // ========================================================
  // Register decode
  logic [7:0] reg_idx;
  logic       reg_hit;

  assign reg_idx = reg_addr - USR_BASE;
  assign reg_hit = (reg_addr >= USR_BASE) && (reg_idx < USR_CNT); // RQ5

  // ========================================================
  // User selectors
  logic [NUSR-1:0][7:0] sel_q;
  logic [NUSR-1:0]      user_vec;
  logic [NUSR-1:0]      user_present;

  for (genvar u = 0; u < NUSR; u++) begin : g_user
    localparam bit PRES = HAS_TIMER_B2 ||
      !(u == `EVUM_USER_B2_CAPTURE || u == `EVUM_USER_B2_COUNT);

    assign user_present[u] = PRES; // RQ2

    evum_user_sel #(
      .NUM_CHAN (NUM_CHAN),
      .PRESENT  (PRES)
    ) u_sel (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .clk_en   (clk_en),
      .wr_en    (reg_wr && reg_hit && reg_idx == 8'(u)), // RQ5
      .wdata    (reg_wdata),
      .chan_evt (chan_evt), // RQ6
      .sel      (sel_q[u]),
      .user_evt (user_vec[u])
    );
  end

  // User bits land on named destinations
  assign users = evum_users_t'(user_vec); // RQ8 RQ9 RQ10 RQ11 RQ12

  // ========================================================
  // Read path
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd && reg_hit) begin
        reg_rdata <= sel_q[reg_idx[4:0]];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ========================================================
  // Sequences
  sequence s_write_last;
    clk_en && reg_wr && reg_addr == USR_LAST;
  endsequence

  sequence s_read_last;
    clk_en && reg_rd && !reg_wr && reg_addr == USR_LAST;
  endsequence

  sequence s_chan0_fire;
    clk_en && next_chan[0];
  endsequence

  sequence s_user0_on_chan0;
    clk_en && sel_q[0] == 8'h01;
  endsequence

  // ========================================================
  // Register checks
  a_sel_readback: assert property ( // RQ5
    s_write_last ##1 s_read_last
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("selector read back wrong");

  a_rdata_idle: assert property (
    clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  a_unmapped_zero: assert property ( // RQ5
    clk_en && reg_rd && (reg_addr < USR_BASE ||
      reg_addr >= USR_BASE + USR_CNT)
    |=> reg_rdata == 8'h00)
    else $error("unmapped address read nonzero");

  a_b2_sel_absent: assert property ( // RQ2
    clk_en && reg_rd && !HAS_TIMER_B2 &&
      reg_addr == USR_BASE + 8'(`EVUM_USER_B2_CAPTURE)
    |=> reg_rdata == 8'h00)
    else $error("absent timer selector readable");

  // ========================================================
  // Generator checks
  a_gen_b1_capture: assert property ( // RQ1
    clk_en && gen_code[0] == `EVUM_GEN_B1_CAPTURE &&
      timer_b[1].mode != EVUM_TB_PERIODIC
    |=> chan_evt[0] == $past(timer_b[1].capture))
    else $error("timer B1 capture not routed");

  a_gen_b1_wrap: assert property ( // RQ1
    clk_en && gen_code[0] == `EVUM_GEN_B1_WRAP
    |=> chan_evt[0] == $past(timer_b[1].wrap))
    else $error("timer B1 wrap not routed");

  a_gen_b2_gone: assert property ( // RQ2
    clk_en && !HAS_TIMER_B2 &&
      (gen_code[0] == `EVUM_GEN_B2_CAPTURE ||
       gen_code[0] == `EVUM_GEN_B2_WRAP)
    |=> !chan_evt[0])
    else $error("absent timer produced an event");

  a_pin_gated: assert property ( // RQ3
    clk_en && gen_code[0][7:3] == PIN_BASE[7:3] &&
      !pin_drv_en[gen_code[0][2:0]]
    |=> !chan_evt[0])
    else $error("pin event with driver disabled");

  a_capture_periodic: assert property ( // RQ4
    clk_en && gen_code[0] == `EVUM_GEN_B0_CAPTURE &&
      timer_b[0].mode == EVUM_TB_PERIODIC
    |=> chan_evt[0] == $past(timer_b[0].wrap))
    else $error("periodic capture not on wrap");

  a_async_mode: assert property ( // RQ13
    clk_en ##0 $changed(timer_b[0].mode)
    |=> capture_async[0] ==
        ($past(timer_b[0].mode) == EVUM_TB_SINGLE_SHOT))
    else $error("capture path kind wrong");

  // ========================================================
  // End-to-end user check
  a_user_follow: assert property ( // RQ6 RQ7 RQ8
    s_user0_on_chan0 and s_chan0_fire ##1 s_user0_on_chan0
    |=> users.table0_event_in_a)
    else $error("user missed channel event");

  a_user_shared: assert property ( // RQ6
    clk_en && sel_q[0] == sel_q[1]
    |=> users.table0_event_in_a == users.table0_event_in_b)
    else $error("shared channel users differ");

  // ========================================================
  // Write, routing and clock enable checks
  a_write_lands: assert property ( // RQ5
    clk_en && reg_wr && reg_hit && user_present[reg_idx[4:0]]
    |=> sel_q[$past(reg_idx[4:0])] == $past(reg_wdata))
    else $error("selector write lost");

  a_write_refused: assert property ( // RQ2
    clk_en && reg_wr && reg_hit && !user_present[reg_idx[4:0]]
    |=> sel_q[$past(reg_idx[4:0])] == `EVUM_SEL_OFF)
    else $error("absent selector took a write");

  a_gen_b2_capture: assert property ( // RQ1
    clk_en && HAS_TIMER_B2 && gen_code[0] == `EVUM_GEN_B2_CAPTURE &&
      timer_b[2].mode != EVUM_TB_PERIODIC
    |=> chan_evt[0] == $past(timer_b[2].capture))
    else $error("timer B2 capture not routed");

  a_gen_b2_wrap: assert property ( // RQ1
    clk_en && HAS_TIMER_B2 && gen_code[0] == `EVUM_GEN_B2_WRAP
    |=> chan_evt[0] == $past(timer_b[2].wrap))
    else $error("timer B2 wrap not routed");

  a_pin_passes: assert property ( // RQ3
    clk_en && gen_code[0][7:3] == PIN_BASE[7:3] &&
      pin_drv_en[gen_code[0][2:0]]
    |=> chan_evt[0] == $past(pin_event[gen_code[0][2:0]]))
    else $error("enabled pin event lost");

  a_b1_periodic: assert property ( // RQ4
    clk_en && gen_code[0] == `EVUM_GEN_B1_CAPTURE &&
      timer_b[1].mode == EVUM_TB_PERIODIC
    |=> chan_evt[0] == $past(timer_b[1].wrap))
    else $error("timer B1 periodic capture not on wrap");

  a_other_pass: assert property (
    clk_en && gen_code[0][7:3] != PIN_BASE[7:3] &&
      !(gen_code[0] inside {[`EVUM_GEN_B0_CAPTURE:`EVUM_GEN_B2_WRAP]})
    |=> chan_evt[0] == $past(chan_other[0]))
    else $error("foreign generator not passed");

  a_chan_freeze: assert property (
    !clk_en |=> $stable(chan_evt))
    else $error("channel events moved while frozen");

  a_rdata_freeze: assert property (
    !clk_en |=> $stable(reg_rdata))
    else $error("read data moved while frozen");

  a_async_freeze: assert property (
    !clk_en |=> $stable(capture_async))
    else $error("capture path flag moved while frozen");

  a_users_freeze: assert property (
    !clk_en |=> $stable(users))
    else $error("user events moved while frozen");

endmodule : evum_mux

// ===== tb/evum_gen_model.sv
// Behavioural model of the event generators and port pins
`timescale 1ns/1ps

module evum_gen_model
  import evum_pkg::*;
(
  input  wire logic [2:0]        cap,
  input  wire logic [2:0]        wrap,
  input  wire logic [2:0]        mode,
  input  wire logic [7:0]        pin_req,
  input  wire logic [7:0]        pin_drv_en,
  output evum_tb_in_t [2:0]      timer_b,
  output logic        [7:0]      pin_event
);
  // ========================================================
  // Timer event sources
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      timer_b[i].capture = cap[i];
      timer_b[i].wrap    = wrap[i];
      timer_b[i].mode    = evum_tb_mode_t'(mode);
    end
  end

  // ========================================================
  // A disabled pin floats; show it high to stress masking
  assign pin_event = pin_req | ~pin_drv_en;
endmodule : evum_gen_model

// ===== tb/tb.sv
// Self-checking bench for the event user channel mux
`timescale 1ns/1ps

module tb;
  import evum_pkg::*;
  typedef struct packed {
    logic [7:0] code;
    logic [2:0] cap;
    logic [2:0] wrap;
    logic [2:0] mode;
    logic [7:0] pin;
    logic [7:0] drv;
    logic       oth;
    logic       exp;
  } evum_row_t;
  localparam int NCH = 6;
  logic                mclk = 0, rstn = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]          reg_addr = 0, reg_wdata = 0, reg_rdata, pin_event;
  logic [7:0]          pin = 0, drv = 8'hff;
  logic [NCH-1:0][7:0] gen_code = {NCH{8'h33}};
  logic [NCH-1:0]      chan_other = 0, chan_evt;
  logic [2:0]          cap = 0, wrap = 0, mode = 0, capture_async;
  evum_tb_in_t [2:0]   timer_b;
  evum_users_t         users;
  int                  bad_count = 0, total_checks = 0, cycles = 0;
  evum_row_t           rows [12] = '{
    '{8'ha2, 3'b010, 3'b000, 3'h2, 8'h00, 8'hff, 1'b0, 1'b1},
    '{8'ha2, 3'b000, 3'b010, 3'h2, 8'h00, 8'hff, 1'b0, 1'b0},
    '{8'ha2, 3'b000, 3'b010, 3'h0, 8'h00, 8'hff, 1'b0, 1'b1},
    '{8'ha3, 3'b000, 3'b010, 3'h2, 8'h00, 8'hff, 1'b0, 1'b1},
    '{8'ha3, 3'b010, 3'b101, 3'h2, 8'h00, 8'hff, 1'b0, 1'b0},
    '{8'ha4, 3'b100, 3'b000, 3'h2, 8'h00, 8'hff, 1'b0, 1'b1},
    '{8'ha5, 3'b000, 3'b100, 3'h2, 8'h00, 8'hff, 1'b0, 1'b1},
    '{8'ha5, 3'b011, 3'b011, 3'h2, 8'h00, 8'hff, 1'b0, 1'b0},
    '{8'h40, 3'b000, 3'b000, 3'h2, 8'h01, 8'hff, 1'b0, 1'b1},
    '{8'h40, 3'b000, 3'b000, 3'h2, 8'h00, 8'hfe, 1'b0, 1'b0},
    '{8'h47, 3'b000, 3'b000, 3'h2, 8'h80, 8'hff, 1'b0, 1'b1},
    '{8'h33, 3'b000, 3'b000, 3'h2, 8'h00, 8'hff, 1'b1, 1'b1}};

  evum_mux #(.NUM_CHAN(NCH)) evum_mux_inst (.mclk(mclk), .rstn(rstn),
    .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gen_code(gen_code), .chan_other(chan_other), .pin_event(pin_event),
    .pin_drv_en(drv), .timer_b(timer_b), .chan_evt(chan_evt),
    .capture_async(capture_async), .users(users));
  evum_gen_model evum_gen_model_inst (.cap(cap), .wrap(wrap), .mode(mode),
    .pin_req(pin), .pin_drv_en(drv), .timer_b(timer_b),
    .pin_event(pin_event));

  // ========================================================
  // Clock and timeout
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      close_out();
    end
  end

  // ========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, d);
  endtask : rd

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // ========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    #1 chk({users, chan_evt}, 0);
    repeat (3) @(posedge mclk);
    for (int n = 0; n < 25; n++) rd(8'h20 + n[7:0], 8'h00);
    rd(8'h1f, 8'h00);
    wr(8'h39, 8'h01);
    rd(8'h39, 8'h00);
    $display("test registers done");
    wr(8'h20, 8'h01);
    wr(8'h21, 8'h01);
    wr(8'h2f, 8'h01);
    wr(8'h30, 8'h01);
    wr(8'h30, 8'h00);
    wr(8'h33, 8'h01);
    wr(8'h31, 8'h07);
    wr(8'h32, 8'h02);
    wr(8'h2d, 8'h02);
    rd(8'h31, 8'h07);
    foreach (rows[i]) begin
      @(posedge mclk);
      gen_code[0]   <= rows[i].code;
      cap           <= rows[i].cap;
      wrap          <= rows[i].wrap;
      mode          <= rows[i].mode;
      pin           <= rows[i].pin;
      drv           <= rows[i].drv;
      chan_other[0] <= rows[i].oth;
      @(posedge mclk);
      #1 chk(chan_evt[0], rows[i].exp);
      @(posedge mclk);
      #1 chk({users.table0_event_in_a, users.table0_event_in_b,
              users.timer_a_inst0_count_input_a,
              users.timer_b_inst1_capture, users.timer_a_inst0_count_input_b,
              users.timer_b_inst0_capture, users.timer_b_inst0_count},
             {{4{rows[i].exp}}, 3'b000});
      @(posedge mclk);
      {cap, wrap, pin, chan_other} <= 0;
      repeat (2) @(posedge mclk);
    end
    $display("test routing table done");
    chan_other <= 6'b000010;
    repeat (2) @(posedge mclk);
    #1 chk({users.timer_b_inst0_count, users.serial_port0_irda,
            users.table0_event_in_a}, 3'b110);
    @(posedge mclk);
    chan_other <= 0;
    $display("test channel n-1 done");
    for (int m = 0; m < 8; m++) begin
      @(posedge mclk);
      mode <= m[2:0];
      repeat (2) @(posedge mclk);
      #1 chk(capture_async, {3{m == 6}});
    end
    $display("test capture path done");
    @(posedge mclk);
    clk_en     <= 1'b0;
    chan_other <= 6'b000001;
    repeat (3) @(posedge mclk);
    #1 chk(chan_evt[0], 1'b0);
    @(posedge mclk);
    clk_en <= 1'b1;
    @(posedge mclk);
    #1 chk(chan_evt[0], 1'b1);
    @(posedge mclk);
    chan_other <= 0;
    $display("test clock enable done");
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= 8'h38;
    reg_wdata <= 8'ha5;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'ha5);
    @(posedge mclk);
    #1 chk(reg_rdata, 8'h00);
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk({users, chan_evt}, 0);
    @(posedge mclk);
    rd(8'h38, 8'h00);
    $display("test back to back and reset done");
    close_out();
  end
endmodule : tb
